/* src/pci_top.sv */
// pin change interrupt block with avalon-mm register slave
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pci_defs.svh"
module pci_top (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire pci_pkg::pci_pins_t PIN_SCHMITT,
	input wire pci_pkg::pci_pins_t PIN_TTL,
	input wire logic SLEEP,
	input wire logic [5:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic CHANGE_IRQ,
	output logic WAKE,
	output logic EVENT_IRQ
);
	import pci_pkg::*;

	// ****************************************
	// registers
	// ****************************************
	pci_pins_t rise_edge_enable_r;
	pci_pins_t fall_edge_enable_r;
	pci_pins_t pin_change_flags_r;
	pci_pins_t input_threshold_select_r;
	pci_pins_t analog_select_r;
	logic change_int_master_enable_r;
	logic [1:0] ev_stat_r;
	logic [1:0] ev_en_r;
	logic [31:0] rdata_r;
	pci_bus_state_t st_r;
	pci_bus_state_t st_nxt;
	logic change_int_summary_flag;
	logic wr_fire;
	logic rd_fire;
	logic wr_lane0;
	logic wake_ev;
	logic [1:0] ev_set;

	pci_pin_if pif ();

	assign pif.pin_raw = PIN_SCHMITT;
	assign pif.schmitt_sel = input_threshold_select_r;
	assign pif.analog_sel = analog_select_r;
	assign pif.rise_en = rise_edge_enable_r;
	assign pif.fall_en = fall_edge_enable_r;

	pci_edge_det u_det (
		.clk(CLK),
		.rst_n(RST_N),
		.ce(CE),
		.pin_ttl(PIN_TTL),
		.pif(pif)
	);

	function automatic logic [31:0] pad6(input pci_pins_t v);
		pad6 = {26'h0, v};
	endfunction : pad6

	function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
		hit = (a == b);
	endfunction : hit

	// ****************************************
	// avalon slave: one wait cycle, then acknowledge
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			PCI_IDLE: begin
				if (AVS_READ || AVS_WRITE) begin
					st_nxt = PCI_ACK;
				end
			end
			PCI_ACK: st_nxt = PCI_HOLD;
			PCI_HOLD: st_nxt = PCI_IDLE;
			default: st_nxt = PCI_IDLE;
		endcase
	end

	// hold state lets the master drop its request before a new one is seen
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			st_r <= PCI_IDLE;
		end else if (CE) begin
			st_r <= st_nxt;
		end
	end

	assign AVS_WAITREQUEST = (st_r != PCI_ACK);
	assign wr_fire = CE && (st_r == PCI_ACK) && AVS_WRITE;
	assign rd_fire = CE && (st_r == PCI_IDLE) && AVS_READ;
	assign wr_lane0 = wr_fire && AVS_BYTEENABLE[0];

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rise_edge_enable_r <= 6'(`PCI_RST_REG);
			fall_edge_enable_r <= 6'(`PCI_RST_REG);
			input_threshold_select_r <= 6'(`PCI_RST_REG);
			analog_select_r <= 6'(`PCI_RST_ANALOG);
			change_int_master_enable_r <= 1'b0;
			ev_en_r <= 2'h0;
		end else if (wr_lane0) begin
			if (hit(AVS_ADDRESS, `PCI_ADDR_RISE))
				rise_edge_enable_r <= AVS_WRITEDATA[5:0];
			if (hit(AVS_ADDRESS, `PCI_ADDR_FALL))
				fall_edge_enable_r <= AVS_WRITEDATA[5:0];
			if (hit(AVS_ADDRESS, `PCI_ADDR_THRESH))
				input_threshold_select_r <= AVS_WRITEDATA[5:0];
			if (hit(AVS_ADDRESS, `PCI_ADDR_ANALOG))
				analog_select_r <= AVS_WRITEDATA[5:0];
			if (hit(AVS_ADDRESS, `PCI_ADDR_CTRL))
				change_int_master_enable_r <= AVS_WRITEDATA[`PCI_CTRL_MASTER_BIT];
			if (hit(AVS_ADDRESS, `PCI_ADDR_EVEN))
				ev_en_r <= AVS_WRITEDATA[1:0];
		end
	end

	// ****************************************
	// change flags
	// ****************************************
	// flags keep running when the master enable is off; only the request is held back
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			pin_change_flags_r <= 6'(`PCI_RST_REG);
		end else if (CE) begin
			if (wr_lane0 && hit(AVS_ADDRESS, `PCI_ADDR_FLAGS))
				pin_change_flags_r <= AVS_WRITEDATA[5:0] | pif.edge_hit;
			else
				pin_change_flags_r <= pin_change_flags_r | pif.edge_hit;
		end
	end

	assign change_int_summary_flag = |pin_change_flags_r;
	assign CHANGE_IRQ = change_int_master_enable_r && change_int_summary_flag;
	// wake is combinational from the detector so it rises one cycle before the flag is set
	assign wake_ev = SLEEP && change_int_master_enable_r && (|pif.edge_hit);
	assign WAKE = wake_ev || (SLEEP && CHANGE_IRQ);

	// ****************************************
	// event status, clear and enable
	// ****************************************
	assign ev_set = {wake_ev, |pif.edge_hit};
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ev_stat_r <= 2'h0;
		end else if (CE) begin
			if (wr_lane0 && hit(AVS_ADDRESS, `PCI_ADDR_EVCLR))
				ev_stat_r <= (ev_stat_r & ~AVS_WRITEDATA[1:0]) | ev_set;
			else
				ev_stat_r <= ev_stat_r | ev_set;
		end
	end
	assign EVENT_IRQ = |(ev_stat_r & ev_en_r);

	// ****************************************
	// read path, captured in the wait cycle
	// ****************************************
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rdata_r <= 32'h0;
		end else if (rd_fire) begin
			case (AVS_ADDRESS)
				`PCI_ADDR_RISE: rdata_r <= pad6(rise_edge_enable_r);
				`PCI_ADDR_FALL: rdata_r <= pad6(fall_edge_enable_r);
				`PCI_ADDR_FLAGS: rdata_r <= pad6(pin_change_flags_r);
				`PCI_ADDR_THRESH: rdata_r <= pad6(input_threshold_select_r);
				`PCI_ADDR_ANALOG: rdata_r <= pad6(analog_select_r);
				`PCI_ADDR_PORT: rdata_r <= pad6(pif.port_val);
				`PCI_ADDR_CTRL: rdata_r <= {30'h0, change_int_summary_flag,
					change_int_master_enable_r};
				`PCI_ADDR_EVSTAT: rdata_r <= {30'h0, ev_stat_r};
				`PCI_ADDR_EVEN: rdata_r <= {30'h0, ev_en_r};
				default: rdata_r <= 32'h0;
			endcase
		end
	end
	assign AVS_READDATA = rdata_r;

	// ****************************************
	// checks
	// ****************************************
	property p_flag_set;
		@(posedge CLK) disable iff (!RST_N)
		(CE && pif.edge_hit[0]) |=> pin_change_flags_r[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("edge did not set flag");

	property p_set_wins;
		@(posedge CLK) disable iff (!RST_N)
		(wr_lane0 && hit(AVS_ADDRESS, `PCI_ADDR_FLAGS) && pif.edge_hit[2])
			|=> pin_change_flags_r[2];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat edge");

	property p_clear;
		@(posedge CLK) disable iff (!RST_N)
		(wr_lane0 && hit(AVS_ADDRESS, `PCI_ADDR_FLAGS) && !AVS_WRITEDATA[2]
			&& !pif.edge_hit[2]) |=> !pin_change_flags_r[2];
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");

	property p_irq_gate;
		@(posedge CLK) disable iff (!RST_N)
		CHANGE_IRQ |-> (change_int_master_enable_r && pin_change_flags_r != 6'h00);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without cause");

	property p_no_irq_off;
		@(posedge CLK) disable iff (!RST_N)
		(!change_int_master_enable_r && CE && pif.edge_hit[5]
			&& !(wr_lane0 && hit(AVS_ADDRESS, `PCI_ADDR_CTRL)))
			|=> (pin_change_flags_r[5] && !CHANGE_IRQ);
	endproperty
	a_no_irq_off: assert property (p_no_irq_off) else $error("master off misbehaves");

	sequence s_rise;
		CE && rise_edge_enable_r[4] && pif.port_val[4] && !$past(pif.port_val[4]);
	endsequence
	property p_rise;
		@(posedge CLK) disable iff (!RST_N)
		s_rise |-> pif.edge_hit[4];
	endproperty
	a_rise: assert property (p_rise) else $error("rise missed");

	property p_fall_off;
		@(posedge CLK) disable iff (!RST_N)
		(!fall_edge_enable_r[5] && !pif.port_val[5]) |-> !pif.edge_hit[5];
	endproperty
	a_fall_off: assert property (p_fall_off) else $error("disarmed fall fired");

	property p_wake;
		@(posedge CLK) disable iff (!RST_N)
		(SLEEP && change_int_master_enable_r && CE && pif.edge_hit != 6'h00)
			|-> WAKE ##1 (pin_change_flags_r != 6'h00);
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on edge");

	property p_hi_zero;
		@(posedge CLK) disable iff (!RST_N)
		(!AVS_WAITREQUEST && AVS_READ) |-> (AVS_READDATA[7:6] == 2'h0);
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("bits 7:6 not zero");

	sequence s_fall;
		CE && fall_edge_enable_r[1] && !pif.port_val[1] && $past(pif.port_val[1]);
	endsequence
	property p_fall;
		@(posedge CLK) disable iff (!RST_N)
		s_fall |-> pif.edge_hit[1];
	endproperty
	a_fall: assert property (p_fall) else $error("fall missed");

	property p_both;
		@(posedge CLK) disable iff (!RST_N)
		(CE && rise_edge_enable_r[2] && fall_edge_enable_r[2]
			&& pif.port_val[2] != $past(pif.port_val[2])) |-> pif.edge_hit[2];
	endproperty
	a_both: assert property (p_both) else $error("either edge missed");

	sequence s_ctrl_ack;
		!AVS_WAITREQUEST && AVS_READ && hit(AVS_ADDRESS, `PCI_ADDR_CTRL);
	endsequence
	property p_summary_rd;
		@(posedge CLK) disable iff (!RST_N)
		s_ctrl_ack |-> (AVS_READDATA[1] == $past(pin_change_flags_r != 6'h00));
	endproperty
	a_summary_rd: assert property (p_summary_rd) else $error("summary read wrong");

	property p_rst_en;
		@(posedge CLK)
		!RST_N |=> (rise_edge_enable_r == 6'h00 && fall_edge_enable_r == 6'h00);
	endproperty
	a_rst_en: assert property (p_rst_en) else $error("enables not reset");

	// four cycles give the level time to clear both stages and the compare register
	property p_analog;
		@(posedge CLK) disable iff (!RST_N)
		(CE && analog_select_r[4])[*4] |-> (!pif.port_val[4] && !pif.edge_hit[4]);
	endproperty
	a_analog: assert property (p_analog) else $error("analog pin seen");

	property p_edge_change;
		@(posedge CLK) disable iff (!RST_N)
		(CE && $past(CE))
			|-> ((pif.edge_hit & ~(pif.port_val ^ $past(pif.port_val))) == 6'h00);
	endproperty
	a_edge_change: assert property (p_edge_change) else $error("edge without change");

	sequence s_req;
		CE && st_r == PCI_IDLE && (AVS_READ || AVS_WRITE);
	endsequence
	property p_wait;
		@(posedge CLK) disable iff (!RST_N)
		s_req |=> !AVS_WAITREQUEST;
	endproperty
	a_wait: assert property (p_wait) else $error("no answer after one wait cycle");

	property p_ack_once;
		@(posedge CLK) disable iff (!RST_N)
		(CE && !AVS_WAITREQUEST) |=> AVS_WAITREQUEST;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("answer held too long");

	property p_ce_freeze;
		@(posedge CLK) disable iff (!RST_N)
		!CE |=> ($stable(pin_change_flags_r) && $stable(st_r) && $stable(ev_stat_r));
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while frozen");

	property p_ev_sticky;
		@(posedge CLK) disable iff (!RST_N)
		(ev_stat_r[0] && !(wr_lane0 && hit(AVS_ADDRESS, `PCI_ADDR_EVCLR) && AVS_WRITEDATA[0]))
			|=> ev_stat_r[0];
	endproperty
	a_ev_sticky: assert property (p_ev_sticky) else $error("event status lost");

	property p_edge_ev;
		@(posedge CLK) disable iff (!RST_N)
		(CE && pif.edge_hit != 6'h00) |=> ev_stat_r[`PCI_EV_CHANGE_BIT];
	endproperty
	a_edge_ev: assert property (p_edge_ev) else $error("edge event not recorded");

	property p_flag_hold;
		@(posedge CLK) disable iff (!RST_N)
		(pin_change_flags_r[0] && !(wr_lane0 && hit(AVS_ADDRESS, `PCI_ADDR_FLAGS)))
			|=> pin_change_flags_r[0];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

	property p_wake_gate;
		@(posedge CLK) disable iff (!RST_N)
		WAKE |-> (SLEEP && change_int_master_enable_r);
	endproperty
	a_wake_gate: assert property (p_wake_gate) else $error("wake without cause");

	property p_irq_on;
		@(posedge CLK) disable iff (!RST_N)
		(change_int_master_enable_r && pin_change_flags_r != 6'h00) |-> CHANGE_IRQ;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("irq missing");

	property p_wr_rise;
		@(posedge CLK) disable iff (!RST_N)
		(wr_lane0 && hit(AVS_ADDRESS, `PCI_ADDR_RISE))
			|=> (rise_edge_enable_r == $past(AVS_WRITEDATA[5:0]));
	endproperty
	a_wr_rise: assert property (p_wr_rise) else $error("rise enable write lost");
endmodule : pci_top
`default_nettype wire

/* src/pci_defs.svh */
// constants of the pin change interrupt block
// Function
// - threshold bit per pin: 1 schmitt levels, 0 ttl levels, reads and detection
// - bits 7 and 6 of the four port registers read zero
// - edges keep setting flags while master enable is clear
// - per-pin rising detector armed by its rise enable bit
// - per-pin falling detector armed by its fall enable bit
// - both enables set: either edge sets the flag; any pin mix allowed
// - enabled edge sets flag; interrupt only with master enable
// - summary flag is the or of all pin flags, read only
// - software clears a flag by writing zero to it
// - edge during a flag write leaves that flag set
// - enabled edge in sleep wakes device when master enable set
// - edge seen in sleep is in the flags before wake completes
// - rise enable bits 5..0 map pins 5..0, reset to zero
// - fall enable bits 5..0 map pins 5..0, reset to zero
// - analog-selected pin gives no digital input to reads or detection
`ifndef PCI_DEFS_SVH
`define PCI_DEFS_SVH
// ****************************************
// register byte addresses
// ****************************************
`define PCI_ADDR_RISE 6'h00
`define PCI_ADDR_FALL 6'h04
`define PCI_ADDR_FLAGS 6'h08
`define PCI_ADDR_THRESH 6'h0c
`define PCI_ADDR_CTRL 6'h10
`define PCI_ADDR_ANALOG 6'h14
`define PCI_ADDR_PORT 6'h18
`define PCI_ADDR_EVSTAT 6'h1c
`define PCI_ADDR_EVCLR 6'h20
`define PCI_ADDR_EVEN 6'h24
// ****************************************
// fields and reset values
// ****************************************
`define PCI_CTRL_MASTER_BIT 0
`define PCI_CTRL_SUMMARY_BIT 1
`define PCI_EV_CHANGE_BIT 0
`define PCI_EV_WAKE_BIT 1
`define PCI_RST_REG 8'h00
`define PCI_RST_ANALOG 8'h00
`endif

/* src/pci_pkg.sv */
// types of the pin change interrupt block
package pci_pkg;
	typedef enum logic [2:0] {
		PCI_IDLE = 3'b001,
		PCI_ACK = 3'b010,
		PCI_HOLD = 3'b100
	} pci_bus_state_t;
	typedef logic [5:0] pci_pins_t;
endpackage : pci_pkg

/* src/pci_pin_if.sv */
// per-pin signals between the top and the edge detector
`timescale 1ns/1ps
`default_nettype none
interface pci_pin_if;
	import pci_pkg::*;
	pci_pins_t pin_raw;
	pci_pins_t schmitt_sel;
	pci_pins_t analog_sel;
	pci_pins_t rise_en;
	pci_pins_t fall_en;
	pci_pins_t port_val;
	pci_pins_t edge_hit;
	modport det (input pin_raw, schmitt_sel, analog_sel, rise_en, fall_en,
		output port_val, edge_hit);
	modport top (output pin_raw, schmitt_sel, analog_sel, rise_en, fall_en,
		input port_val, edge_hit);
endinterface : pci_pin_if
`default_nettype wire

/* src/pci_edge_det.sv */
// synchroniser and rise/fall detectors for the six port pins
`timescale 1ns/1ps
`default_nettype none
module pci_edge_det (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [5:0] pin_ttl,
	pci_pin_if.det pif
);
	import pci_pkg::*;
	pci_pins_t sync1_r;
	pci_pins_t sync2_r;
	pci_pins_t prev_r;
	pci_pins_t level;
	// choose buffer per pin; analog pins see a constant low, so no edges arise once a high level has left the stages
	assign level = ~pif.analog_sel &
		((pif.schmitt_sel & pif.pin_raw) | (~pif.schmitt_sel & pin_ttl));
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_r <= 6'h00;
			sync2_r <= 6'h00;
			prev_r <= 6'h00;
		end else if (ce) begin
			sync1_r <= level;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end
	assign pif.port_val = sync2_r;
	assign pif.edge_hit = (pif.rise_en & sync2_r & ~prev_r)
		| (pif.fall_en & ~sync2_r & prev_r);
endmodule : pci_edge_det
`default_nettype wire

/* test/pci_pin_src.sv */
// far-side model of the six port pins feeding both input buffers
`timescale 1ns/1ps
`default_nettype none
module pci_pin_src (
	input wire logic [5:0] lvl,
	input wire logic [5:0] skew,
	output logic [5:0] schmitt,
	output logic [5:0] ttl
);
	// skew stands for a slow edge caught between thresholds: the ttl buffer lags
	assign schmitt = lvl;
	assign ttl = lvl ^ skew;
endmodule : pci_pin_src
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the pin change interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "pci_defs.svh"
module tb_top;
	import pci_pkg::*;
	logic clk, rst_n, ce, rd_s, wr_s, sleep, wait_s, chg_irq, wake, ev_irq;
	logic [5:0] addr, lvl, skew;
	logic [31:0] wdata, rdata, v, m;
	logic [3:0] be;
	pci_pins_t p_st, p_tt;
	int miscompares = 0;
	int checks = 0;
	int n;
	pci_pin_src pci_pin_src_i (.lvl(lvl), .skew(skew), .schmitt(p_st), .ttl(p_tt));
	pci_top pci_top_i (.CLK(clk), .RST_N(rst_n), .CE(ce), .PIN_SCHMITT(p_st),
		.PIN_TTL(p_tt), .SLEEP(sleep), .AVS_ADDRESS(addr), .AVS_READ(rd_s),
		.AVS_WRITE(wr_s), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_s), .CHANGE_IRQ(chg_irq),
		.WAKE(wake), .EVENT_IRQ(ev_irq));
	// ****
	// bus access and checking
	// ****
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// the extra edge after release keeps a following request from landing in the same step
	task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
		rd_s <= !w;
		wr_s <= w;
		addr <= a;
		wdata <= d;
		do @(posedge clk); while (wait_s !== 1'b0);
		v = rdata;
		rd_s <= 1'b0;
		wr_s <= 1'b0;
		@(posedge clk);
	endtask : acc
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		chk(v, exp);
	endtask : rd
	// flag lands three edges after a pin change; one more for margin
	task automatic pins(input logic [5:0] l);
		lvl <= l;
		repeat (4) @(posedge clk);
	endtask : pins
	task automatic test_done;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#50000;
		miscompares++;
		test_done();
	end
	// ****
	// tests
	// ****
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		rd_s = 1'b0;
		wr_s = 1'b0;
		addr = 6'h00;
		wdata = 32'h0;
		be = 4'hf;
		sleep = 1'b0;
		lvl = 6'h00;
		skew = 6'h00;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`PCI_ADDR_RISE, 32'h0);
		rd(`PCI_ADDR_FALL, 32'h0);
		rd(`PCI_ADDR_FLAGS, 32'h0);
		rd(`PCI_ADDR_THRESH, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(6'(4 * i), 32'hff);
			rd(6'(4 * i), 32'h3f);
		end
		rd(6'h3c, 32'h0);
		be <= 4'he;
		wr(`PCI_ADDR_RISE, 32'h01);
		be <= 4'hf;
		rd(`PCI_ADDR_RISE, 32'h3f);
		wr(`PCI_ADDR_THRESH, 32'h00);
		wr(`PCI_ADDR_RISE, 32'h01);
		wr(`PCI_ADDR_FALL, 32'h02);
		wr(`PCI_ADDR_FLAGS, 32'h00);
		pins(6'h03);
		rd(`PCI_ADDR_FLAGS, 32'h01);
		chk(32'(chg_irq), 32'h0);
		pins(6'h00);
		rd(`PCI_ADDR_FLAGS, 32'h03);
		rd(`PCI_ADDR_CTRL, 32'h02);
		wr(`PCI_ADDR_CTRL, 32'h01);
		chk(32'(chg_irq), 32'h1);
		// software clear by masking only the bits already seen
		acc(1'b0, `PCI_ADDR_FLAGS, 32'h0);
		m = v ^ 32'hff;
		acc(1'b0, `PCI_ADDR_FLAGS, 32'h0);
		wr(`PCI_ADDR_FLAGS, v & m);
		rd(`PCI_ADDR_FLAGS, 32'h0);
		chk(32'(chg_irq), 32'h0);
		rd(`PCI_ADDR_CTRL, 32'h01);
		wr(`PCI_ADDR_RISE, 32'h04);
		wr(`PCI_ADDR_FALL, 32'h04);
		pins(6'h04);
		rd(`PCI_ADDR_FLAGS, 32'h04);
		wr(`PCI_ADDR_FLAGS, 32'h00);
		pins(6'h00);
		rd(`PCI_ADDR_FLAGS, 32'h04);
		wr(`PCI_ADDR_FLAGS, 32'h00);
		// the flag sets on the very edge at which the clearing write acts
		lvl <= 6'h04;
		@(posedge clk);
		wr(`PCI_ADDR_FLAGS, 32'h00);
		rd(`PCI_ADDR_FLAGS, 32'h04);
		pins(6'h00);
		wr(`PCI_ADDR_RISE, 32'h08);
		wr(`PCI_ADDR_FLAGS, 32'h00);
		skew <= 6'h08;
		pins(6'h08);
		rd(`PCI_ADDR_PORT, 32'h00);
		rd(`PCI_ADDR_FLAGS, 32'h00);
		wr(`PCI_ADDR_THRESH, 32'h08);
		pins(6'h08);
		rd(`PCI_ADDR_PORT, 32'h08);
		rd(`PCI_ADDR_FLAGS, 32'h08);
		skew <= 6'h00;
		pins(6'h00);
		wr(`PCI_ADDR_ANALOG, 32'h10);
		wr(`PCI_ADDR_RISE, 32'h10);
		wr(`PCI_ADDR_FLAGS, 32'h00);
		pins(6'h10);
		rd(`PCI_ADDR_PORT, 32'h00);
		rd(`PCI_ADDR_FLAGS, 32'h00);
		pins(6'h00);
		wr(`PCI_ADDR_ANALOG, 32'h00);
		// same pin once digital again: the rise must now be seen
		pins(6'h10);
		rd(`PCI_ADDR_FLAGS, 32'h10);
		wr(`PCI_ADDR_FLAGS, 32'h00);
		wr(`PCI_ADDR_RISE, 32'h20);
		wr(`PCI_ADDR_CTRL, 32'h00);
		sleep <= 1'b1;
		pins(6'h20);
		chk(32'(wake), 32'h0);
		rd(`PCI_ADDR_FLAGS, 32'h20);
		wr(`PCI_ADDR_FLAGS, 32'h00);
		pins(6'h00);
		wr(`PCI_ADDR_CTRL, 32'h01);
		lvl <= 6'h20;
		n = 0;
		while (wake !== 1'b1 && n < 8) begin
			@(posedge clk);
			n++;
		end
		chk(32'(wake), 32'h1);
		rd(`PCI_ADDR_FLAGS, 32'h20);
		sleep <= 1'b0;
		// event interrupt: raise, mask, clear
		wr(`PCI_ADDR_EVEN, 32'h03);
		rd(`PCI_ADDR_EVSTAT, 32'h03);
		chk(32'(ev_irq), 32'h1);
		wr(`PCI_ADDR_EVEN, 32'h00);
		chk(32'(ev_irq), 32'h0);
		wr(`PCI_ADDR_EVEN, 32'h03);
		wr(`PCI_ADDR_EVCLR, 32'h01);
		rd(`PCI_ADDR_EVSTAT, 32'h02);
		wr(`PCI_ADDR_EVCLR, 32'h02);
		rd(`PCI_ADDR_EVSTAT, 32'h00);
		chk(32'(ev_irq), 32'h0);
		// clock enable low freezes the detector; the fall is only seen once it runs again
		wr(`PCI_ADDR_FALL, 32'h20);
		wr(`PCI_ADDR_FLAGS, 32'h00);
		ce <= 1'b0;
		lvl <= 6'h00;
		repeat (4) @(posedge clk);
		chk(32'(chg_irq), 32'h0);
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		chk(32'(chg_irq), 32'h1);
		chk(32'(ev_irq), 32'h1);
		rd(`PCI_ADDR_FLAGS, 32'h20);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`PCI_ADDR_RISE, 32'h0);
		rd(`PCI_ADDR_FALL, 32'h0);
		rd(`PCI_ADDR_FLAGS, 32'h0);
		rd(`PCI_ADDR_CTRL, 32'h0);
		test_done();
	end
endmodule : tb_top
`default_nettype wire
